// *** rtl/lec_top.sv ***
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
module lec_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // transmit fifo side
  input wire logic async_transmit_retries_zero,
  input wire logic [11:0] async_transmit_fifo_bytes,
  input wire logic async_transmit_eop_in_fifo,
  input wire logic async_transmit_underrun,
  input wire logic async_transmit_pkt_done,
  output logic async_transmit_start,
  // isochronous stamp
  input wire logic [5:0] cip_format_field,
  output logic cip_stamp_apply,
  // link controls
  output logic out_of_order_pipeline_off,
  output logic priority_arb_on,
  output logic phy_accel_notify
);
  logic rst_meta;
  logic rst_n;
  logic [31:0] ctrl;
  logic saf_mode;
  logic ack;
  logic [31:0] wmask;
  logic [31:0] next_ctrl;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // one wait cycle per access, then acknowledge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end
    wmask = wmask & lec_pkg::LEC_WRITE_MASK;
    next_ctrl = (ctrl & ~wmask) | (avs_writedata & wmask);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= lec_pkg::LEC_CTRL_RESET;
    end else if (avs_write && ack && avs_address == lec_pkg::LEC_CTRL_OFFSET) begin
      ctrl <= next_ctrl;
    end
  end

  // status word: store-and-forward state in bit 0
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
      if (avs_address == lec_pkg::LEC_CTRL_OFFSET) begin
        avs_readdata <= ctrl & lec_pkg::LEC_WRITE_MASK;
      end else if (avs_address == lec_pkg::LEC_STAT_OFFSET) begin
        avs_readdata <= {31'h0000_0000, saf_mode};
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  assign out_of_order_pipeline_off = ctrl[lec_pkg::LEC_PIPE_OFF_BIT];
  assign priority_arb_on = ctrl[lec_pkg::LEC_PRIO_BIT];
  assign phy_accel_notify = ctrl[lec_pkg::LEC_ACCEL_BIT];

  lec_tx_gate u_gate (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .thresh_code(ctrl[lec_pkg::LEC_THRESH_LO +: 2]),
    .retries_zero(async_transmit_retries_zero),
    .fifo_bytes(async_transmit_fifo_bytes),
    .eop_in_fifo(async_transmit_eop_in_fifo),
    .underrun(async_transmit_underrun),
    .pkt_done(async_transmit_pkt_done),
    .tx_start(async_transmit_start),
    .saf_mode(saf_mode)
  );

  lec_stamp_sel u_stamp (
    .mpeg_cip_stamp_on(ctrl[lec_pkg::LEC_MPEG_BIT]),
    .dv_cip_stamp_on(ctrl[lec_pkg::LEC_DV_BIT]),
    .cip_format_field(cip_format_field),
    .stamp_apply(cip_stamp_apply)
  );
endmodule

// *** rtl/lec_pkg.sv ***
package lec_pkg;
  // register byte address on the Avalon-MM slave
  localparam logic [7:0] LEC_CTRL_OFFSET = 8'hF4;
  localparam logic [7:0] LEC_STAT_OFFSET = 8'hF0;
  localparam logic [31:0] LEC_CTRL_RESET = 32'h0000_1000;
  localparam logic [31:0] LEC_WRITE_MASK = 32'h0000_B582;
  // field positions
  localparam int LEC_PIPE_OFF_BIT = 15;
  localparam int LEC_THRESH_LO = 12;
  localparam int LEC_MPEG_BIT = 10;
  localparam int LEC_DV_BIT = 8;
  localparam int LEC_PRIO_BIT = 7;
  localparam int LEC_ACCEL_BIT = 1;
  // threshold codes and levels in bytes
  localparam logic [1:0] LEC_THR_2K = 2'h0;
  localparam logic [1:0] LEC_THR_1K7 = 2'h1;
  localparam logic [1:0] LEC_THR_1K = 2'h2;
  localparam logic [1:0] LEC_THR_512 = 2'h3;
  localparam logic [11:0] LEC_BYTES_2K = 12'h800;
  localparam logic [11:0] LEC_BYTES_1K7 = 12'h6CD;
  localparam logic [11:0] LEC_BYTES_1K = 12'h400;
  localparam logic [11:0] LEC_BYTES_512 = 12'h200;
  // cip format codes
  localparam logic [5:0] LEC_FMT_MPEG = 6'h20;
  localparam logic [5:0] LEC_FMT_DV = 6'h00;
  typedef enum logic [2:0] {
    LEC_IDLE = 3'h1,
    LEC_FILL = 3'h2,
    LEC_SEND = 3'h4
  } lec_tx_state_t;
endpackage

// *** rtl/lec_stamp_sel.sv ***
module lec_stamp_sel (
  // control
  input wire logic mpeg_cip_stamp_on,
  input wire logic dv_cip_stamp_on,
  // stream
  input wire logic [5:0] cip_format_field,
  output logic stamp_apply
);
  always_comb begin
    stamp_apply = 1'b0;
    if (mpeg_cip_stamp_on && cip_format_field == lec_pkg::LEC_FMT_MPEG) begin
      stamp_apply = 1'b1;
    end
    if (dv_cip_stamp_on && cip_format_field == lec_pkg::LEC_FMT_DV) begin
      stamp_apply = 1'b1;
    end
  end
endmodule

// *** rtl/lec_tx_gate.sv ***
module lec_tx_gate (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic [1:0] thresh_code,
  input wire logic retries_zero,
  // fifo status
  input wire logic [11:0] fifo_bytes,
  input wire logic eop_in_fifo,
  input wire logic underrun,
  input wire logic pkt_done,
  output logic tx_start,
  output logic saf_mode
);
  logic [11:0] level;
  logic underrun_seen;
  always_comb begin
    unique case (thresh_code)
      lec_pkg::LEC_THR_2K: level = lec_pkg::LEC_BYTES_2K;
      lec_pkg::LEC_THR_1K7: level = lec_pkg::LEC_BYTES_1K7;
      lec_pkg::LEC_THR_1K: level = lec_pkg::LEC_BYTES_1K;
      lec_pkg::LEC_THR_512: level = lec_pkg::LEC_BYTES_512;
    endcase
  end
  // sticky after an underrun: the retry and later packets run store-and-forward
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      underrun_seen <= 1'b0;
    end else if (underrun) begin
      underrun_seen <= 1'b1;
    end
  end
  assign saf_mode = (thresh_code == lec_pkg::LEC_THR_2K) || retries_zero || underrun_seen;
  always_comb begin
    tx_start = eop_in_fifo;
    if (!saf_mode && fifo_bytes >= level && !pkt_done) begin
      tx_start = 1'b1;
    end
  end
endmodule

// *** dv/lec_top_props.sv ***
module lec_top_props (
  // watched ports
  input wire logic clk_sys, nrst, avs_read, avs_write, avs_waitrequest,
  input wire logic [7:0] avs_address,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata, avs_readdata,
  input wire logic [11:0] async_transmit_fifo_bytes,
  input wire logic [5:0] cip_format_field,
  input wire logic async_transmit_retries_zero, async_transmit_eop_in_fifo,
  input wire logic async_transmit_start, cip_stamp_apply, priority_arb_on,
  input wire logic out_of_order_pipeline_off, phy_accel_notify
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_wr;
    avs_write && !avs_waitrequest && avs_address == 8'hF4 && avs_byteenable == 4'hF;
  endsequence
  property p_pipe; s_wr |=> out_of_order_pipeline_off == $past(avs_writedata[15]); endproperty
  a_pipe: assert property (p_pipe) else $error("pipeline control wrong");
  property p_prio; s_wr |=> priority_arb_on == $past(avs_writedata[7]); endproperty
  a_prio: assert property (p_prio) else $error("priority control wrong");
  property p_accel; s_wr |=> phy_accel_notify == $past(avs_writedata[1]); endproperty
  a_accel: assert property (p_accel) else $error("accel notify wrong");
  property p_eop; async_transmit_eop_in_fifo |-> async_transmit_start; endproperty
  a_eop: assert property (p_eop) else $error("no start with whole packet");
  property p_rz; async_transmit_retries_zero && !async_transmit_eop_in_fifo |-> !async_transmit_start;
  endproperty
  a_rz: assert property (p_rz) else $error("start while retries zero");
  property p_thr; !async_transmit_eop_in_fifo && async_transmit_fifo_bytes < 12'h200
    |-> !async_transmit_start; endproperty
  a_thr: assert property (p_thr) else $error("start below threshold");
  property p_fmt; cip_format_field != 6'h20 && cip_format_field != 6'h00 |-> !cip_stamp_apply;
  endproperty
  a_fmt: assert property (p_fmt) else $error("stamp on other format");
  // reserved positions of the control word read back as zero
  property p_rsv; avs_read && !avs_waitrequest && avs_address == 8'hF4
    |=> (avs_readdata & 32'hFFFF4A7D) == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule

bind lec_top lec_top_props u_props (.*);

// *** dv/lec_top_tb.sv ***
module lec_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, nrst = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic async_transmit_retries_zero = 0, async_transmit_eop_in_fifo = 0;
  logic async_transmit_underrun = 0, async_transmit_pkt_done = 0, async_transmit_start;
  logic cip_stamp_apply, out_of_order_pipeline_off, priority_arb_on, phy_accel_notify;
  logic [3:0] avs_byteenable = 4'hF;
  logic [5:0] cip_format_field = 6'h20;
  logic [7:0] avs_address = 8'h00;
  logic [11:0] async_transmit_fifo_bytes = 12'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [11:0] lvl [4] = '{12'h800, 12'h6CD, 12'h400, 12'h200};
  logic [5:0] fm [3] = '{6'h20, 6'h00, 6'h21};
  int mismatches = 0, tests_run = 0;
  lec_top dut_u (.*);
  initial forever #2 clk_sys = ~clk_sys;
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'h0) break;
    end
    if (i == 20) begin
      mismatches++;
      test_done;
    end
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
  endtask
  // fifo level and end-of-packet, then look at the start line mid-cycle
  task st(input logic [11:0] b, input logic e, ex);
    async_transmit_fifo_bytes <= b;
    async_transmit_eop_in_fifo <= e;
    @(negedge clk_sys);
    chk("start", async_transmit_start, ex);
    @(posedge clk_sys);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1;
    repeat (3) @(posedge clk_sys);
    bus(0, 8'hF4, 0);
    chk("reset", rd, 32'h0000_1000);
    bus(0, 8'hF0, 0);
    chk("saf idle", rd, 32'h0);
    bus(1, 8'hF4, 32'hFFFF_FFFF);
    bus(0, 8'hF4, 0);
    chk("ctrl", rd, 32'h0000_B582);
    chk("outs", {out_of_order_pipeline_off, priority_arb_on, phy_accel_notify}, 3'h7);
    bus(0, 8'h10, 0);
    chk("unmapped", rd, 32'h0);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      cip_format_field <= fm[k];
      @(negedge clk_sys);
      chk("stamp", cip_stamp_apply, {31'h0, k < 2});
    end
    bus(1, 8'hF4, 32'h400);
    cip_format_field <= 6'h00;
    @(negedge clk_sys);
    chk("dv off", cip_stamp_apply, 1'h0);
    chk("outs", {out_of_order_pipeline_off, priority_arb_on, phy_accel_notify}, 3'h0);
    for (int c = 1; c < 4; c++) begin
      bus(1, 8'hF4, {18'h0, c[1:0], 12'h0});
      st(lvl[c], 0, 1);
      st(lvl[c] - 12'h001, 0, 0);
    end
    bus(1, 8'hF4, 32'h0);
    st(12'h800, 0, 0);
    st(12'h800, 1, 1);
    bus(1, 8'hF4, 32'h3000);
    async_transmit_retries_zero <= 1;
    st(12'h800, 0, 0);
    async_transmit_retries_zero <= 0;
    async_transmit_pkt_done <= 1;
    st(12'h800, 0, 0);
    async_transmit_pkt_done <= 0;
    async_transmit_underrun <= 1;
    @(posedge clk_sys);
    async_transmit_underrun <= 0;
    st(12'h800, 0, 0);
    st(12'h800, 1, 1);
    bus(0, 8'hF0, 0);
    chk("saf after underrun", rd, 32'h1);
    test_done;
  end
endmodule
